// ---- src/slsi_pkg.sv ----
/*
  Package for the scan-line sync inserter: register map, field positions,
  reset values, sequencer states, timing counts and bus carrier structs.
  Assumes a 20 MHz system clock and a 2.4 kHz carrier derived from it.
*/
package slsi_pkg;

  // ==========================================================
  // timing
  // ==========================================================
  localparam int unsigned SYS_CLK_HZ      = 20000000;
  localparam int unsigned CARRIER_HZ      = 2400;
  localparam int unsigned CARRIER_HALF    = SYS_CLK_HZ / (2 * CARRIER_HZ);
  localparam int unsigned BURST_PULSES    = 7;
  localparam int unsigned DIVIDE_STAGES   = 3;
  localparam int unsigned PULSE_CNT_W     = 4;

  // ==========================================================
  // register map (byte addresses)
  // ==========================================================
  localparam logic [7:0] CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] COUNT_OFFSET  = 8'h08;

  // control field positions
  localparam int unsigned CTRL_DAY_BIT     = 0;
  localparam int unsigned CTRL_NIGHT_BIT   = 1;
  localparam int unsigned CTRL_IR_BIT      = 2;
  localparam int unsigned CTRL_VIS_BIT     = 3;
  localparam logic [3:0]  CTRL_RESET_VALUE = 4'h0;

  // status field positions
  localparam int unsigned STAT_STATE_LSB   = 0;
  localparam int unsigned STAT_LATCH_BIT   = 2;
  localparam int unsigned STAT_SWITCH_BIT  = 3;
  localparam int unsigned STAT_SYNC_BIT    = 4;
  localparam int unsigned STAT_IRSW_BIT    = 5;
  localparam int unsigned STAT_VISSW_BIT   = 6;
  localparam int unsigned STAT_DISABLE_BIT = 7;

  // ==========================================================
  // sequencer states
  // ==========================================================
  typedef enum logic [1:0] {
    SLSI_REST  = 2'b00,
    SLSI_BURST = 2'b01,
    SLSI_HOLD  = 2'b11,
    SLSI_CLEAR = 2'b10
  } slsi_state_type;

  // ==========================================================
  // bus carriers
  // ==========================================================
  typedef struct packed {
    logic        hsel;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
  } slsi_ahb_req_type;

  typedef struct packed {
    logic [3:0] mode;
  } slsi_ctrl_type;

endpackage

// ---- src/slsi_sync3.sv ----
/*
  Three-stage input synchroniser with agreement filter.
  Assumes the input is asynchronous to clk_in; output changes once the
  second and third stages agree.
*/
`timescale 1ns/100ps
`default_nettype none
module slsi_sync3 (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic async_in,
  output var  logic level_out
);

  logic [2:0] stage;

  // ==========================================================
  // shift chain and agreement
  // ==========================================================
  // first stage feeds only the second
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      stage <= 3'h0;
    end else begin
      stage <= {stage[1:0], async_in};
    end
  end

  // output follows only when stages two and three agree
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      level_out <= 1'b0;
    end else if (stage[1] == stage[2]) begin
      level_out <= stage[2];
    end
  end

endmodule
`default_nettype wire

// ---- src/slsi_top.sv ----
/*
  Scan-line sync inserter: seven-pulse 300 Hz burst sequencer, series
  switch control, day/night mode selection, output disable and chopper
  drive, with an AHB-Lite register slave.
  Assumes a 20 MHz mclk_in; the 2.4 kHz carrier is derived internally,
  telemetry_release arrives asynchronously from the radiometer.
*/
// Our own choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module slsi_top #(
  parameter int unsigned PULSE_TARGET = slsi_pkg::BURST_PULSES
) (
  input  wire logic                       mclk_in,
  input  wire logic                       rst_n_in,
  input  wire logic                       telemetry_release_in,
  input  wire slsi_pkg::slsi_ahb_req_type ahb_req_in,
  input  wire logic [31:0]                hwdata_in,
  output var  logic [31:0]                hrdata_out,
  output var  logic                       hreadyout_out,
  output var  logic                       hresp_out,
  output var  logic                       sync_out,
  output var  logic                       switch_control_out,
  output var  logic                       ir_input_switch_out,
  output var  logic                       balance_switch_out,
  output var  logic                       visible_input_switch_out,
  output var  logic                       disable_logic_out,
  output var  logic                       chopper_a_out,
  output var  logic                       chopper_b_out
);

  localparam int unsigned HALF_W = $clog2(slsi_pkg::CARRIER_HALF);

  // ==========================================================
  // elaboration checks
  // ==========================================================
  if (PULSE_TARGET < 1 || PULSE_TARGET > 15) begin : g_bad_target
    $error("pulse target does not fit the four-bit counter");
  end

  // ==========================================================
  // declarations
  // ==========================================================
  slsi_pkg::slsi_state_type state;
  slsi_pkg::slsi_state_type next_state;
  slsi_pkg::slsi_ctrl_type  ctrl;
  logic [HALF_W-1:0]        half_cnt;
  logic                     carrier;
  logic                     carrier_rise;
  logic                     release_sync;
  logic                     burst_start_latch;
  logic                     divider_stage_a;
  logic                     divider_stage_b;
  logic                     divider_stage_c;
  logic                     sync_delay_stage;
  logic                     sync_delay_prev;
  logic                     next_sync_delay;
  logic [3:0]               pulse_count;
  logic                     idle_hold;
  logic                     clock_gate;
  logic                     count_tick;
  logic                     day_en;
  logic                     night_en;
  logic                     ir_en;
  logic                     vis_en;
  logic                     route_ir;
  logic                     route_vis;
  logic                     dp_write;
  logic                     dp_read;
  logic [7:0]               dp_addr;

  // ==========================================================
  // carrier generator
  // ==========================================================
  // 2.4 kHz square wave from the system clock
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      half_cnt <= '0;
      carrier  <= 1'b0;
    end else if (half_cnt == HALF_W'(slsi_pkg::CARRIER_HALF - 1)) begin
      half_cnt <= '0;
      carrier  <= ~carrier;
    end else begin
      half_cnt <= half_cnt + HALF_W'(1);
    end
  end

  // one-cycle marker of each carrier rising edge
  assign carrier_rise = (half_cnt == HALF_W'(slsi_pkg::CARRIER_HALF - 1))
                        && !carrier;

  // ==========================================================
  // trigger synchroniser
  // ==========================================================
  slsi_sync3 u_release_sync (
    .clk_in    (mclk_in),
    .rst_n_in  (rst_n_in),
    .async_in  (telemetry_release_in),
    .level_out (release_sync)
  );

  // ==========================================================
  // start latch
  // ==========================================================
  // set by trigger at carrier edge, cleared on leaving state 4
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      burst_start_latch <= 1'b0;
    end else if (carrier_rise) begin
      if (release_sync && state == slsi_pkg::SLSI_REST) begin
        burst_start_latch <= 1'b1;
      end else if (state == slsi_pkg::SLSI_CLEAR) begin
        burst_start_latch <= 1'b0;
      end
    end
  end

  // divider and counter held while trigger absent
  assign idle_hold  = !release_sync;
  assign clock_gate = burst_start_latch && carrier_rise;

  // ==========================================================
  // divide-by-eight chain and delay follower
  // ==========================================================
  // counts down from all ones, so the first half period is high
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      divider_stage_a <= 1'b1;
      divider_stage_b <= 1'b1;
      divider_stage_c <= 1'b1;
    end else if (idle_hold) begin
      divider_stage_a <= 1'b1;
      divider_stage_b <= 1'b1;
      divider_stage_c <= 1'b1;
    end else if (clock_gate) begin
      divider_stage_a <= ~divider_stage_a;
      divider_stage_b <= divider_stage_b ^ ~divider_stage_a;
      divider_stage_c <= divider_stage_c
                         ^ (~divider_stage_a & ~divider_stage_b);
    end
  end

  // value the follower takes at this edge
  assign next_sync_delay = idle_hold ? 1'b1
                           : (carrier_rise ? divider_stage_c
                                           : sync_delay_stage);

  // follower copies last stage one carrier clock later
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      sync_delay_stage <= 1'b1;
      sync_delay_prev  <= 1'b1;
    end else begin
      sync_delay_prev <= sync_delay_stage;
      if (idle_hold) begin
        sync_delay_stage <= 1'b1;
      end else if (carrier_rise) begin
        sync_delay_stage <= divider_stage_c;
      end
    end
  end

  // ==========================================================
  // pulse counter
  // ==========================================================
  // count on the falling edge of the delayed 300 Hz in state 2
  assign count_tick = (state == slsi_pkg::SLSI_BURST) && sync_delay_prev
                      && !sync_delay_stage;

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      pulse_count <= 4'h0;
    end else if (idle_hold) begin
      pulse_count <= 4'h0;
    end else if (count_tick) begin
      pulse_count <= pulse_count + 4'h1;
    end
  end

  // ==========================================================
  // sequencer
  // ==========================================================
  always_comb begin
    next_state = state;
    unique case (state)
      slsi_pkg::SLSI_REST: begin
        if (carrier_rise && burst_start_latch) begin
          next_state = slsi_pkg::SLSI_BURST;
        end
      end
      slsi_pkg::SLSI_BURST: begin
        if (pulse_count == 4'(PULSE_TARGET)) begin
          next_state = slsi_pkg::SLSI_HOLD;
        end
      end
      slsi_pkg::SLSI_HOLD: begin
        if (carrier_rise && !release_sync) begin
          next_state = slsi_pkg::SLSI_CLEAR;
        end
      end
      slsi_pkg::SLSI_CLEAR: begin
        if (carrier_rise) begin
          next_state = slsi_pkg::SLSI_REST;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      state <= slsi_pkg::SLSI_REST;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // sync and switch outputs
  // ==========================================================
  // sync only in state 2; switches open only in state 2
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      sync_out           <= 1'b0;
      switch_control_out <= 1'b1;
    end else begin
      // follows the follower's new value, so no pulse gains a clock
      sync_out <= (next_state == slsi_pkg::SLSI_BURST)
                  && next_sync_delay;
      switch_control_out <= (next_state != slsi_pkg::SLSI_BURST);
    end
  end

  // ==========================================================
  // mode selection, disable, chopper
  // ==========================================================
  assign day_en    = ctrl.mode[slsi_pkg::CTRL_DAY_BIT];
  assign night_en  = ctrl.mode[slsi_pkg::CTRL_NIGHT_BIT];
  assign ir_en     = ctrl.mode[slsi_pkg::CTRL_IR_BIT];
  assign vis_en    = ctrl.mode[slsi_pkg::CTRL_VIS_BIT];
  assign route_vis = day_en && vis_en && !night_en;
  assign route_ir  = !route_vis && (night_en || (day_en && ir_en));

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      ir_input_switch_out      <= 1'b0;
      balance_switch_out       <= 1'b0;
      visible_input_switch_out <= 1'b0;
      disable_logic_out        <= 1'b1;
    end else begin
      visible_input_switch_out <= route_vis;
      ir_input_switch_out      <= route_ir;
      balance_switch_out       <= route_ir;
      disable_logic_out        <= !(day_en || night_en);
    end
  end

  // opposite-phase chopper drives
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      chopper_a_out <= 1'b0;
      chopper_b_out <= 1'b1;
    end else begin
      chopper_a_out <= carrier;
      chopper_b_out <= !carrier;
    end
  end

  // ==========================================================
  // AHB-Lite slave
  // ==========================================================
  // latch address phase, zero wait states
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      dp_write <= 1'b0;
      dp_read  <= 1'b0;
      dp_addr  <= 8'h00;
    end else if (ahb_req_in.hready) begin
      dp_write <= ahb_req_in.hsel && ahb_req_in.htrans[1]
                  && ahb_req_in.hwrite;
      dp_read  <= ahb_req_in.hsel && ahb_req_in.htrans[1]
                  && !ahb_req_in.hwrite;
      dp_addr  <= ahb_req_in.haddr;
    end
  end

  // control register write in the data phase
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      ctrl.mode <= slsi_pkg::CTRL_RESET_VALUE;
    end else if (dp_write && dp_addr == slsi_pkg::CTRL_OFFSET) begin
      ctrl.mode <= hwdata_in[3:0];
    end
  end

  // read data registered for the data phase
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      hrdata_out <= 32'h0;
    end else if (ahb_req_in.hready && ahb_req_in.hsel
                 && ahb_req_in.htrans[1] && !ahb_req_in.hwrite) begin
      unique case (ahb_req_in.haddr)
        slsi_pkg::CTRL_OFFSET:   hrdata_out <= {28'h0, ctrl.mode};
        slsi_pkg::STATUS_OFFSET: hrdata_out <= {24'h0,
          disable_logic_out, visible_input_switch_out,
          ir_input_switch_out, sync_out, switch_control_out,
          burst_start_latch, state};
        slsi_pkg::COUNT_OFFSET:  hrdata_out <= {28'h0, pulse_count};
        default:                 hrdata_out <= 32'h0;
      endcase
    end
  end

  // always ready, always OKAY
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
    end else begin
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ---- verif/slsi_radiometer_model.sv ----
/*
  Radiometer timing model: drives the housing-scan-done release level.
  Assumes the bench commands scan end; skew keeps it off the clock edge.
*/
`timescale 1ns/100ps
`default_nettype none
module slsi_radiometer_model (
  input  wire logic scan_end_in,
  output var  logic telemetry_release_out
);
  // ==========================================================
  // release level
  // ==========================================================
  // level follows scan_end_in, a fixed 7.3 ns behind the bench's clock-edge scan end
  initial begin
    telemetry_release_out = 1'b0;
    forever begin
      @(scan_end_in);
      telemetry_release_out <= #(7.3) scan_end_in;
    end
  end
endmodule
`default_nettype wire

// ---- verif/slsi_top_chk.sv ----
/*
  Checker for slsi_top: burst, switch, mode and chopper outputs.
  Assumes it is bound to slsi_top by the bench top file.
*/
`timescale 1ns/100ps
`default_nettype none
module slsi_top_chk #(
  parameter int unsigned PULSE_TARGET = 7
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic telemetry_release_in,
  input wire logic sync_out,
  input wire logic switch_control_out,
  input wire logic ir_input_switch_out,
  input wire logic balance_switch_out,
  input wire logic visible_input_switch_out,
  input wire logic disable_logic_out,
  input wire logic chopper_a_out,
  input wire logic chopper_b_out
);
  localparam int unsigned HALF = slsi_pkg::CARRIER_HALF;
  logic [31:0] chop_cnt;
  logic [31:0] trig_cnt;
  logic [31:0] hi_cnt;
  logic [3:0]  fall_cnt;
  logic        chop_seen;
  logic        chop_prev;
  logic        sync_prev;
  logic        sw_prev;

  // ==========================================================
  // helper counters
  // ==========================================================
  // previous output levels
  always_ff @(posedge mclk_in) begin
    chop_prev <= chopper_a_out;
    sync_prev <= sync_out;
    sw_prev   <= switch_control_out;
  end
  // cycles since the last chopper edge
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      chop_cnt  <= 32'h0;
      chop_seen <= 1'b0;
    end else if (chopper_a_out != chop_prev) begin
      chop_cnt  <= 32'h1;
      chop_seen <= 1'b1;
    end else begin
      chop_cnt <= chop_cnt + 32'h1;
    end
  end
  // trigger age and sync high length
  always_ff @(posedge mclk_in) begin
    trig_cnt <= (!rst_n_in || !telemetry_release_in) ? 32'h0 : trig_cnt + 1;
    hi_cnt   <= (!rst_n_in || !sync_out) ? 32'h0 : hi_cnt + 32'h1;
  end
  // sync pulses seen since the switches opened
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in || (!switch_control_out && sw_prev)) begin
      fall_cnt <= 4'h0;
    end else if (!sync_out && sync_prev) begin
      fall_cnt <= fall_cnt + 4'h1;
    end
  end

  // ==========================================================
  // assertions
  // ==========================================================
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  chk_ir_bal_pair: assert property (
    ir_input_switch_out == balance_switch_out)
    else $error("ir and balance switches differ");
  chk_ir_vis_excl: assert property (
    !(ir_input_switch_out && visible_input_switch_out))
    else $error("both inputs selected");
  chk_dis_ground: assert property (
    disable_logic_out |-> !ir_input_switch_out && !visible_input_switch_out)
    else $error("input selected while disabled");
  chk_chop_opposite: assert property (
    chopper_a_out != chopper_b_out)
    else $error("chopper drives in phase");
  chk_chop_half: assert property (
    (chopper_a_out != chop_prev) && chop_seen |-> chop_cnt == HALF)
    else $error("chopper half period wrong");
  chk_sync_open: assert property (
    sync_out |-> !switch_control_out)
    else $error("sync while switches closed");
  chk_rest_pass: assert property (
    !telemetry_release_in [*8] |-> switch_control_out && !sync_out)
    else $error("burst without trigger");
  chk_burst_delay: assert property (
    $fell(switch_control_out) |-> trig_cnt >= 2 * HALF
      && trig_cnt <= 4 * HALF + 16)
    else $error("burst start delay wrong");
  chk_pulse_width: assert property (
    $fell(sync_out) |-> hi_cnt == 8 * HALF)
    else $error("sync pulse width wrong");
  chk_pulse_count: assert property (
    $rose(switch_control_out) |-> !sync_out
      ##[0:2] fall_cnt == 4'(PULSE_TARGET))
    else $error("burst pulse count wrong");

  cover property ($fell(switch_control_out));
  cover property ($rose(switch_control_out));
  cover property ($fell(disable_logic_out));
endmodule
`default_nettype wire

// ---- verif/slsi_top_tb.sv ----
/*
  Bench for slsi_top: register access, mode table and one sync burst.
  Assumes the radiometer model supplies the trigger level.
*/
`timescale 1ns/100ps
`default_nettype none
module slsi_top_tb;
  localparam int unsigned PT   = 1;
  localparam int unsigned HALF = slsi_pkg::CARRIER_HALF;
  localparam logic [7:0]  CT   = slsi_pkg::CTRL_OFFSET;
  localparam logic [7:0]  ST   = slsi_pkg::STATUS_OFFSET;
  localparam logic [7:0]  CN   = slsi_pkg::COUNT_OFFSET;
  logic        mclk_in, rst_n_in, scan_end, trig, hr_smp;
  logic        b_sel, b_write, rd_phase, pt_stb;
  logic [7:0]  b_addr;
  logic [1:0]  b_trans;
  logic [31:0] hwdata, hrdata, cyc, g, m;
  logic        hready, hresp, sync, sw, irs, bal, viss, dis, cha, chb;
  logic [32:0] exq[$];
  logic [32:0] e;
  logic [3:0]  c, r;
  int          error_cnt, checked;
  slsi_pkg::slsi_ahb_req_type ahb_req;
  assign ahb_req = {b_sel, b_addr, b_trans, b_write, 3'h2, hready};

  slsi_top #(.PULSE_TARGET(PT)) u_dut (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .telemetry_release_in(trig), .ahb_req_in(ahb_req),
    .hwdata_in(hwdata), .hrdata_out(hrdata), .hreadyout_out(hready),
    .hresp_out(hresp), .sync_out(sync), .switch_control_out(sw),
    .ir_input_switch_out(irs), .balance_switch_out(bal),
    .visible_input_switch_out(viss), .disable_logic_out(dis),
    .chopper_a_out(cha), .chopper_b_out(chb));
  slsi_radiometer_model u_rad (
    .scan_end_in(scan_end), .telemetry_release_out(trig));

  // ==========================================================
  // clock, timeout and monitor
  // ==========================================================
  // clock and settled hready copy
  initial begin
    mclk_in = 1'b0;
    forever #25 mclk_in = ~mclk_in;
  end
  always @(negedge mclk_in) hr_smp = hready;
  // cut a hang short
  always @(posedge mclk_in) begin
    cyc = cyc + 32'h1;
    if (cyc == 32'd100000) begin
      error_cnt++;
      end_of_test();
    end
  end
  // compare each result with the oldest note
  always @(posedge mclk_in) begin
    if ((rd_phase && hr_smp) || pt_stb) begin
      e = exq.pop_front();
      g = e[32] ? {28'h0, dis, viss, bal, irs} : hrdata;
      checked++;
      if (g !== e[31:0]) begin
        error_cnt++;
        $display("Error at %0t: got %h expected %h", $time, g, e[31:0]);
      end
    end
    // every response is OKAY
    if (rst_n_in && hresp !== 1'b0) begin
      error_cnt++;
      $display("Error at %0t: hresp %h expected %h", $time, hresp, 1'b0);
    end
  end

  // ==========================================================
  // tasks
  // ==========================================================
  // one single transfer; a read notes its expected data
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] x);
    b_sel   <= 1'b1;
    b_addr  <= a;
    b_trans <= 2'b10;
    b_write <= wr;
    do begin
      @(posedge mclk_in);
    end while (!hr_smp);
    b_sel    <= 1'b0;
    b_trans  <= 2'b00;
    hwdata   <= d;
    rd_phase <= !wr;
    if (!wr) exq.push_back({1'b0, x});
    do begin
      @(posedge mclk_in);
    end while (!hr_smp);
    rd_phase <= 1'b0;
  endtask
  // note and sample the mode outputs
  task automatic port_chk(input logic [31:0] x);
    exq.push_back({1'b1, x});
    pt_stb <= 1'b1;
    @(posedge mclk_in);
    pt_stb <= 1'b0;
  endtask
  // wait for the series switch level under a bound
  task automatic wait_sw(input logic v);
    int n;
    n = 0;
    while (sw !== v && n < 40000) begin
      @(posedge mclk_in);
      n++;
    end
    if (n >= 40000) begin
      error_cnt++;
      end_of_test();
    end
  endtask
  // expected {disable, visible, balance, ir} for a control value
  function automatic logic [31:0] mode(input logic [3:0] k);
    logic v;
    logic ir;
    v = k[0] && k[3] && !k[1];
    ir = !v && (k[1] || (k[0] && k[2]));
    mode = {28'h0, !k[0] && !k[1], v, ir, ir};
  endfunction
  // counts and verdict
  task automatic end_of_test();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ==========================================================
  // main sequence
  // ==========================================================
  initial begin
    rst_n_in = 1'b0;
    {b_sel, b_write, rd_phase, pt_stb, scan_end} = 5'h0;
    {b_addr, b_trans, hwdata, cyc} = '0;
    error_cnt = 0;
    checked = 0;
    r = 4'($urandom(81483));
    repeat (16) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    @(posedge mclk_in);
    bus(1'b0, ST, 32'h0, 32'h88);
    bus(1'b0, CT, 32'h0, 32'h0);
    port_chk(32'h8);
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      c = 4'(i) ^ r;
      bus(1'b1, CT, {28'($urandom()), c}, 32'h0);
      m = mode(c);
      repeat (2) @(posedge mclk_in);
      port_chk(m);
      bus(1'b0, ST, 32'h0, {24'h0, m[3:2], m[0], 5'h08});
      bus(1'b0, CT, 32'h0, {28'h0, c});
    end
    $display("test modes done");
    bus(1'b1, 8'h0c, $urandom(), 32'h0);
    bus(1'b1, ST, 32'hffffffff, 32'h0);
    bus(1'b0, 8'h0c, 32'h0, 32'h0);
    bus(1'b0, CT, 32'h0, {28'h0, c});
    $display("test unmapped done");
    // day with ir enable selects the ir input
    bus(1'b1, CT, 32'h5, 32'h0);
    m = 32'h20;
    repeat ($urandom() % 500) @(posedge mclk_in);
    scan_end <= 1'b1;
    wait_sw(1'b0);
    bus(1'b0, ST, 32'h0, m | 32'h15);
    bus(1'b0, CN, 32'h0, 32'h0);
    wait_sw(1'b1);
    repeat (2000) @(posedge mclk_in);
    bus(1'b0, ST, 32'h0, m | 32'h0f);
    bus(1'b0, CN, 32'h0, 32'(PT));
    scan_end <= 1'b0;
    // clear state lasts one carrier period; allow two
    repeat (4 * HALF) @(posedge mclk_in);
    bus(1'b0, ST, 32'h0, m | 32'h08);
    bus(1'b0, CN, 32'h0, 32'h0);
    repeat (2) @(posedge mclk_in);
    $display("test burst done");
    end_of_test();
  end
endmodule

bind slsi_top slsi_top_chk #(.PULSE_TARGET(PULSE_TARGET)) u_chk (.*);
`default_nettype wire
